// ==== rtl/uhs_map.vh ====
// Register map, field positions, reset values and timing counts for the
// host bulk transfer and session request block. Assumes a 20 MHz clock.
`ifndef UHS_MAP_VH
`define UHS_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UHS_OFS_EPCTL 6'h00
`define UHS_OFS_ADDR 6'h04
`define UHS_OFS_TOKEN 6'h08
`define UHS_OFS_USBIRQ 6'h0c
`define UHS_OFS_OTGIRQ 6'h10
`define UHS_OFS_OTGCTL 6'h14
`define UHS_OFS_CFG2 6'h18
`define UHS_OFS_STAT 6'h1c
`define UHS_OFS_BD_EVEN 6'h20
`define UHS_OFS_BD_ODD 6'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UHS_EP_HSHK 0
`define UHS_EP_LSPEED 7
`define UHS_EP_NAK_RETRY_DISABLE 6
`define UHS_USB_DETACH 0
`define UHS_USB_DONE 3
`define UHS_USB_ATTACH 6
`define UHS_USB_STALL 7
`define UHS_OTG_SESEND 2
`define UHS_OTG_SESVALID 3
`define UHS_OTG_DPPU 7
`define UHS_OTG_DMPU 6
`define UHS_OTG_VBDIS 0
`define UHS_CFG2_VBPULSE 4
`define UHS_BD_OWNER 15

// ------------------------------------------------------------
// Reset values, token and handshake codes
// ------------------------------------------------------------
`define UHS_RST_BYTE 8'h00
`define UHS_RST_BD 16'h0000
`define UHS_PID_OUT 4'h1
`define UHS_PID_IN 4'h9
`define UHS_PID_ACK 4'h2
`define UHS_PID_NAK 4'ha
`define UHS_PID_STALL 4'he
`define UHS_PID_ERR 4'hf

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define UHS_CLK_KHZ 20000
`define UHS_DETACH_NS 2500
`define UHS_DETACH_CYC ((`UHS_DETACH_NS * `UHS_CLK_KHZ + 999999) / 1000000)
`define UHS_HS_TIMEOUT_CYC 8'hff

`endif

// ==== rtl/uhs_sync2.v ====
// Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes the sampled levels change slowly compared with the clock.
`timescale 1ns/100ps
module uhs_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk) begin
    if (reset) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== rtl/uhs_se0_timer.v ====
// SE0 duration timer: reports a detach once SE0 outlasts the limit and an
// attach pulse when the line leaves a detached SE0. Inputs are synchronised.
`timescale 1ns/100ps
`include "uhs_map.vh"
module uhs_se0_timer (
  input wire clk,
  input wire reset,
  input wire se0,
  output reg detach_pulse,
  output reg attach_pulse
);

  localparam integer LIMIT_CYC = `UHS_DETACH_CYC;
  localparam [7:0] LIMIT = LIMIT_CYC[7:0];

  reg [7:0] count_reg;
  reg detached_reg;

  always @(posedge clk) begin
    if (reset) begin
      count_reg <= 8'h00;
      detached_reg <= 1'b0;
      detach_pulse <= 1'b0;
      attach_pulse <= 1'b0;
    end else begin
      detach_pulse <= 1'b0;
      attach_pulse <= 1'b0;
      if (!se0) begin
        count_reg <= 8'h00;
        if (detached_reg) begin
          detached_reg <= 1'b0;
          attach_pulse <= 1'b1;
        end
      end else if (count_reg < LIMIT) begin
        count_reg <= count_reg + 8'h01;
      end else if (!detached_reg) begin
        // Strictly longer than the limit before calling it a detach
        detached_reg <= 1'b1;
        detach_pulse <= 1'b1;
      end
    end
  end

endmodule

// ==== rtl/uhs_host_ctrl.v ====
// Host bulk transfer sequencer with session request controls, reached
// over an Avalon-MM slave with waitrequest. Assumes a packet engine on the
// same clock that sends tokens and data and returns the handshake, and
// asynchronous line-state and VBUS comparator pins.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "uhs_map.vh"
module uhs_host_ctrl (
  input wire clk,
  input wire reset,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg tx_token_valid,
  output reg [3:0] tx_token_pid,
  output reg [6:0] tx_device_address,
  output reg [3:0] tx_endpoint,
  output reg [9:0] tx_byte_count,
  output reg tx_bank_odd,
  output reg tx_low_speed,
  input wire hs_valid,
  input wire [3:0] hs_pid,
  input wire line_dp,
  input wire line_dm,
  input wire vbus_session_valid,
  output reg dplus_pullup_enable,
  output reg dminus_pullup_enable,
  output reg vbus_discharge_enable,
  output reg vbus_pulse_enable
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [7:0] host_endpoint_control_reg;
  reg [7:0] device_address_reg;
  reg [7:0] token_register_reg;
  reg [7:0] usb_irq_flags_reg;
  reg [7:0] otg_irq_flags_reg;
  reg [7:0] otg_control_reg;
  reg [7:0] usb_config2_reg;
  reg [7:0] last_transfer_status_reg;
  reg [15:0] buffer_descriptor_reg [0:1];
  reg bank_odd_reg;
  reg [1:0] state_reg;
  reg [7:0] timeout_reg;
  reg vbus_prev_reg;
  reg [2:0] vbus_warm_reg;

  wire [1:0] line_sync;
  wire vbus_sync;
  wire detach_pulse;
  wire attach_pulse;
  wire access;
  wire wr_en;
  wire [7:0] wbyte;
  wire retry_nak;
  wire hs_done;
  wire hs_late;
  wire xfer_done;
  wire [3:0] done_pid;
  wire [7:0] usb_set;
  wire [7:0] otg_set;
  wire token_wr;
  wire usb_clr;
  wire otg_clr;

  // Byte lane zero carries every register's low byte
  function [7:0] w1c_next;
    input [7:0] cur;
    input [7:0] set;
    input clr_en;
    input [7:0] clr;
    begin
      // A hardware set in the same cycle as a clear wins
      w1c_next = (cur & ~(clr_en ? clr : 8'h00)) | set;
    end
  endfunction

  function sel;
    input [5:0] a;
    input [5:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  // Status byte: endpoint, transmit direction, bank, spare bits read zero
  function [7:0] status_byte;
    input [7:0] token;
    input odd;
    begin
      status_byte = {token[3:0], token[7:4] == `UHS_PID_OUT, odd, 2'b00};
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and SE0 timing
  // ------------------------------------------------------------
  uhs_sync2 #(
    .WIDTH(2)
  ) u_line_sync (
    .clk(clk),
    .reset(reset),
    .async_in({line_dp, line_dm}),
    .sync_out(line_sync)
  );

  uhs_sync2 #(
    .WIDTH(1)
  ) u_vbus_sync (
    .clk(clk),
    .reset(reset),
    .async_in(vbus_session_valid),
    .sync_out(vbus_sync)
  );

  uhs_se0_timer u_se0 (
    .clk(clk),
    .reset(reset),
    .se0(line_sync == 2'b00),
    .detach_pulse(detach_pulse),
    .attach_pulse(attach_pulse)
  );

  // ------------------------------------------------------------
  // Bus access: one wait state, then the access takes effect
  // ------------------------------------------------------------
  assign access = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  // Write strobes for the token and the two write-one-clear flag registers
  assign token_wr = wr_en & sel(avs_address, `UHS_OFS_TOKEN);
  assign usb_clr = wr_en & sel(avs_address, `UHS_OFS_USBIRQ);
  assign otg_clr = wr_en & sel(avs_address, `UHS_OFS_OTGIRQ);

  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (access) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read | avs_write) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= 32'h00000000;
      case (avs_address)
        `UHS_OFS_EPCTL: avs_readdata[7:0] <= host_endpoint_control_reg;
        `UHS_OFS_ADDR: avs_readdata[7:0] <= device_address_reg;
        `UHS_OFS_TOKEN: avs_readdata[7:0] <= token_register_reg;
        `UHS_OFS_USBIRQ: avs_readdata[7:0] <= usb_irq_flags_reg;
        `UHS_OFS_OTGIRQ: avs_readdata[7:0] <= otg_irq_flags_reg;
        `UHS_OFS_OTGCTL: avs_readdata[7:0] <= otg_control_reg;
        `UHS_OFS_CFG2: avs_readdata[7:0] <= usb_config2_reg;
        `UHS_OFS_STAT: avs_readdata[7:0] <= last_transfer_status_reg;
        `UHS_OFS_BD_EVEN: avs_readdata[15:0] <= buffer_descriptor_reg[0];
        `UHS_OFS_BD_ODD: avs_readdata[15:0] <= buffer_descriptor_reg[1];
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // Speed and pull-up bits are not locked while busy; software is trusted
  // to set them during setup only.
  always @(posedge clk) begin
    if (reset) begin
      host_endpoint_control_reg <= `UHS_RST_BYTE;
      device_address_reg <= `UHS_RST_BYTE;
      otg_control_reg <= `UHS_RST_BYTE;
      usb_config2_reg <= `UHS_RST_BYTE;
    end else if (wr_en) begin
      if (sel(avs_address, `UHS_OFS_EPCTL)) begin
        host_endpoint_control_reg <= wbyte;
      end
      if (sel(avs_address, `UHS_OFS_ADDR)) begin
        device_address_reg <= {1'b0, wbyte[6:0]};
      end
      if (sel(avs_address, `UHS_OFS_OTGCTL)) begin
        otg_control_reg <= wbyte;
      end
      if (sel(avs_address, `UHS_OFS_CFG2)) begin
        usb_config2_reg <= wbyte;
      end
    end
  end

  // ------------------------------------------------------------
  // Session request outputs
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      dplus_pullup_enable <= 1'b0;
      dminus_pullup_enable <= 1'b0;
      vbus_discharge_enable <= 1'b0;
      vbus_pulse_enable <= 1'b0;
      tx_low_speed <= 1'b0;
    end else begin
      // Pull-ups follow software directly; timing of the pulse is its job
      dplus_pullup_enable <= otg_control_reg[`UHS_OTG_DPPU];
      dminus_pullup_enable <= otg_control_reg[`UHS_OTG_DMPU];
      vbus_discharge_enable <= otg_control_reg[`UHS_OTG_VBDIS];
      // A VBUS pulse is never driven while the link is set to low speed
      vbus_pulse_enable <= usb_config2_reg[`UHS_CFG2_VBPULSE] &
                           ~host_endpoint_control_reg[`UHS_EP_LSPEED];
      tx_low_speed <= host_endpoint_control_reg[`UHS_EP_LSPEED];
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  assign retry_nak = (hs_pid == `UHS_PID_NAK) &
                     ~host_endpoint_control_reg[`UHS_EP_NAK_RETRY_DISABLE];
  assign hs_done = (state_reg == ST_WAIT) & hs_valid & ~retry_nak;
  assign hs_late = (state_reg == ST_WAIT) & ~hs_valid & (timeout_reg == 8'h00);
  assign xfer_done = hs_done | hs_late;
  assign done_pid = hs_late ? `UHS_PID_ERR :
                    ((hs_pid == `UHS_PID_ACK) | (hs_pid == `UHS_PID_NAK) |
                     (hs_pid == `UHS_PID_STALL)) ? hs_pid : `UHS_PID_ERR;

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      token_register_reg <= `UHS_RST_BYTE;
      timeout_reg <= 8'h00;
      tx_token_valid <= 1'b0;
      tx_token_pid <= 4'h0;
      tx_device_address <= 7'h00;
      tx_endpoint <= 4'h0;
      tx_byte_count <= 10'h000;
      tx_bank_odd <= 1'b0;
    end else begin
      tx_token_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (token_wr) begin
            token_register_reg <= wbyte;
            // A descriptor still owned by the processor is left untouched
            if (buffer_descriptor_reg[bank_odd_reg][`UHS_BD_OWNER]) begin
              state_reg <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          tx_token_valid <= 1'b1;
          tx_token_pid <= token_register_reg[7:4];
          tx_endpoint <= token_register_reg[3:0];
          tx_device_address <= device_address_reg[6:0];
          tx_byte_count <= buffer_descriptor_reg[bank_odd_reg][9:0];
          tx_bank_odd <= bank_odd_reg;
          timeout_reg <= `UHS_HS_TIMEOUT_CYC;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (hs_valid && retry_nak) begin
            state_reg <= ST_SEND;
          end else if (xfer_done) begin
            state_reg <= ST_IDLE;
          end else begin
            timeout_reg <= timeout_reg - 8'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Descriptors, bank pointer and status
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      buffer_descriptor_reg[0] <= `UHS_RST_BD;
      buffer_descriptor_reg[1] <= `UHS_RST_BD;
      bank_odd_reg <= 1'b0;
      last_transfer_status_reg <= `UHS_RST_BYTE;
    end else if (xfer_done) begin
      // Hand back to the processor with the handshake in the PID field
      buffer_descriptor_reg[bank_odd_reg][`UHS_BD_OWNER] <= 1'b0;
      buffer_descriptor_reg[bank_odd_reg][13:10] <= done_pid;
      bank_odd_reg <= ~bank_odd_reg;
      last_transfer_status_reg <= status_byte(token_register_reg, bank_odd_reg);
    end else if (wr_en && sel(avs_address, `UHS_OFS_BD_EVEN)) begin
      buffer_descriptor_reg[0] <= avs_writedata[15:0];
    end else if (wr_en && sel(avs_address, `UHS_OFS_BD_ODD)) begin
      buffer_descriptor_reg[1] <= avs_writedata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt flags, write one to clear
  // ------------------------------------------------------------
  assign usb_set = {(xfer_done && done_pid == `UHS_PID_STALL), attach_pulse, 2'b00,
                    xfer_done, 2'b00, detach_pulse};
  // VBUS edges count only once the warm-up below has run out
  assign otg_set = {4'h0, vbus_sync & ~vbus_prev_reg,
                    ~vbus_sync & vbus_prev_reg, 2'b00} &
                   {8{vbus_warm_reg[2]}};

  always @(posedge clk) begin
    if (reset) begin
      usb_irq_flags_reg <= `UHS_RST_BYTE;
      otg_irq_flags_reg <= `UHS_RST_BYTE;
      vbus_prev_reg <= 1'b0;
    end else begin
      vbus_prev_reg <= vbus_sync;
      usb_irq_flags_reg <= w1c_next(usb_irq_flags_reg, usb_set,
                                    usb_clr,
                                    wbyte);
      otg_irq_flags_reg <= w1c_next(otg_irq_flags_reg, otg_set,
                                    otg_clr,
                                    wbyte);
    end
  end

  // ------------------------------------------------------------
  // VBUS edge warm-up
  // ------------------------------------------------------------
  // The synchroniser leaves reset low, so a VBUS already present would
  // look like a fresh rise and raise a false session-valid flag
  always @(posedge clk) begin
    if (reset) begin
      vbus_warm_reg <= 3'b000;
    end else begin
      vbus_warm_reg <= {vbus_warm_reg[1:0], 1'b1};
    end
  end

endmodule

// ==== tb/uhs_host_ctrl_checker.sv ====
// Checker for the host transfer and session request block, bound in.
// Assumes one clock domain and the offsets of the register map header.
`timescale 1ns/100ps
`include "uhs_map.vh"
module uhs_host_ctrl_checker (
  input wire clk,
  input wire reset,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire tx_token_valid,
  input wire [3:0] tx_token_pid,
  input wire [6:0] tx_device_address,
  input wire [3:0] tx_endpoint,
  input wire tx_low_speed,
  input wire hs_valid,
  input wire [3:0] hs_pid,
  input wire dplus_pullup_enable,
  input wire dminus_pullup_enable,
  input wire vbus_discharge_enable,
  input wire vbus_pulse_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Shadow registers
  // ----------------------------------------
  reg [7:0] ep_reg;
  reg [7:0] addr_reg;
  reg [7:0] cfg_reg;
  reg [7:0] otg_reg;
  reg wait_reg;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  always @(posedge clk) begin
    if (reset) begin
      ep_reg <= 8'h00;
      addr_reg <= 8'h00;
      cfg_reg <= 8'h00;
      otg_reg <= 8'h00;
      wait_reg <= 1'b0;
    end else begin
      if (wr_ok && avs_address == `UHS_OFS_EPCTL) ep_reg <= avs_writedata[7:0];
      if (wr_ok && avs_address == `UHS_OFS_ADDR) addr_reg <= avs_writedata[7:0];
      if (wr_ok && avs_address == `UHS_OFS_CFG2) cfg_reg <= avs_writedata[7:0];
      if (wr_ok && avs_address == `UHS_OFS_OTGCTL) otg_reg <= avs_writedata[7:0];
      // A silent partner leaves this set; the next token restarts it anyway
      if (tx_token_valid) wait_reg <= 1'b1;
      else if (hs_valid) wait_reg <= 1'b0;
    end
  end
  sequence s_otg_wr;
    wr_ok && avs_address == `UHS_OFS_OTGCTL;
  endsequence
  sequence s_nak;
    hs_valid && wait_reg && hs_pid == `UHS_PID_NAK && !ep_reg[`UHS_EP_NAK_RETRY_DISABLE];
  endsequence
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one wait cycle");
  property p_retry;
    s_nak |-> ##2 tx_token_valid;
  endproperty
  a_retry: assert property (p_retry) else $error("nak not retried");
  property p_addr;
    tx_token_valid |-> tx_device_address == addr_reg[6:0];
  endproperty
  a_addr: assert property (p_addr) else $error("token address wrong");
  property p_pulse;
    tx_token_valid |=> !tx_token_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("token pulse too long");
  property p_hold;
    !tx_token_valid |-> $stable({tx_token_pid, tx_device_address, tx_endpoint});
  endproperty
  a_hold: assert property (p_hold) else $error("token fields moved");
  property p_pullups;
    s_otg_wr |-> ##2 ({dplus_pullup_enable, dminus_pullup_enable, vbus_discharge_enable}
      == {otg_reg[7], otg_reg[6], otg_reg[0]});
  endproperty
  a_pullups: assert property (p_pullups) else $error("otg outputs wrong");
  property p_low_speed;
    tx_low_speed == $past(ep_reg[`UHS_EP_LSPEED]);
  endproperty
  a_low_speed: assert property (p_low_speed) else $error("low speed wrong");
  property p_srp_speed;
    vbus_pulse_enable == $past(cfg_reg[4] && !ep_reg[`UHS_EP_LSPEED]);
  endproperty
  a_srp_speed: assert property (p_srp_speed) else $error("vbus pulse wrong");
  property p_status;
    avs_read && !avs_waitrequest && avs_address == `UHS_OFS_STAT
      |-> avs_readdata[31:8] == 24'h0 && avs_readdata[1:0] == 2'h0;
  endproperty
  a_status: assert property (p_status) else $error("status spare bits set");
endmodule

// ==== tb/uhs_pkt_engine_model.sv ====
// Packet engine stand-in: answers each token with a handshake.
// Assumes the block's clock; a zero answer code means stay silent.
`timescale 1ns/100ps
`include "uhs_map.vh"
module uhs_pkt_engine_model (
  input wire clk,
  input wire reset,
  input wire tx_token_valid,
  input wire [3:0] mode_pid,
  input wire [3:0] nak_count,
  output reg hs_valid,
  output reg [3:0] hs_pid,
  output integer n_tokens
);
  reg [7:0] cnt_reg;
  reg busy_reg;
  reg [3:0] naks_reg;
  always @(posedge clk) begin
    hs_valid <= 1'b0;
    // Code flips outside a pulse so a stale value is never mistaken
    hs_pid <= ~hs_pid;
    if (reset) begin
      busy_reg <= 1'b0;
      naks_reg <= 4'h0;
      n_tokens <= 0;
      hs_pid <= 4'h0;
    end else if (tx_token_valid) begin
      busy_reg <= 1'b1;
      cnt_reg <= 8'h03;
      n_tokens <= n_tokens + 1;
    end else if (busy_reg && cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else if (busy_reg && mode_pid != 4'h0) begin
      busy_reg <= 1'b0;
      hs_valid <= 1'b1;
      if (naks_reg < nak_count) begin
        hs_pid <= `UHS_PID_NAK;
        naks_reg <= naks_reg + 4'h1;
      end else begin
        hs_pid <= mode_pid;
        naks_reg <= 4'h0;
      end
    end
  end
endmodule

// ==== tb/uhs_host_ctrl_tb_top.sv ====
// Self-checking bench for the host transfer and session request block.
// Assumes the packet engine model on the far side and no other master.
`timescale 1ns/100ps
`include "uhs_map.vh"
module uhs_host_ctrl_tb_top;
  reg clk, reset, avs_read, avs_write, line_dp, line_dm, vbus_session_valid;
  reg [5:0] avs_address;
  reg [31:0] avs_writedata, q;
  reg [3:0] avs_byteenable, m_pid, m_nak;
  wire avs_waitrequest, tx_token_valid, tx_bank_odd, tx_low_speed, hs_valid;
  wire dplus_pullup_enable, dminus_pullup_enable, vbus_discharge_enable, vbus_pulse_enable;
  wire [31:0] avs_readdata;
  wire [3:0] tx_token_pid, tx_endpoint, hs_pid;
  wire [6:0] tx_device_address;
  wire [9:0] tx_byte_count;
  integer n_errors = 0, num_checks = 0, cycles = 0, n_tok, t0, i;
  typedef struct { logic rd; logic [5:0] a; logic [31:0] d; } uhs_row_t;
  uhs_row_t rows [0:7] = '{'{1, `UHS_OFS_STAT, 0}, '{1, `UHS_OFS_USBIRQ, 0},
    '{0, `UHS_OFS_ADDR, 32'h25}, '{1, `UHS_OFS_ADDR, 32'h25}, '{0, `UHS_OFS_EPCTL, 32'h1d},
    '{1, `UHS_OFS_EPCTL, 32'h1d}, '{1, 6'h3c, 0}, '{1, `UHS_OFS_OTGIRQ, 0}};
  uhs_host_ctrl u_uhs_host_ctrl (.*);
  uhs_pkt_engine_model u_uhs_pkt_engine_model (.clk(clk), .reset(reset),
    .tx_token_valid(tx_token_valid), .mode_pid(m_pid), .nak_count(m_nak),
    .hs_valid(hs_valid), .hs_pid(hs_pid), .n_tokens(n_tok));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task xfer(input [3:0] ep, input odd, input [3:0] nak, input [3:0] pid, input [3:0] xp,
    input integer ntk);
    m_nak <= nak;
    m_pid <= pid;
    t0 = n_tok;
    bus(0, odd ? `UHS_OFS_BD_ODD : `UHS_OFS_BD_EVEN, 32'h8040);
    bus(0, `UHS_OFS_TOKEN, {24'h0, `UHS_PID_OUT, ep});
    i = 0;
    q = 0;
    while (q[3] !== 1'b1 && i < 300) begin
      bus(1, `UHS_OFS_USBIRQ, 0);
      i = i + 1;
    end
    chk("done", q[3], 1);
    chk("stall flag", q[7], xp == `UHS_PID_STALL);
    chk("tokens", n_tok - t0, ntk);
    bus(1, `UHS_OFS_STAT, 0);
    chk("status", q, {24'h0, ep, 1'b1, odd, 2'h0});
    chk("fields", {tx_token_pid, tx_endpoint, tx_bank_odd, tx_byte_count},
      {`UHS_PID_OUT, ep, odd, 10'h040});
    bus(1, odd ? `UHS_OFS_BD_ODD : `UHS_OFS_BD_EVEN, 0);
    chk("descriptor", q & 32'hbc00, {18'h0, xp, 10'h0});
    bus(0, `UHS_OFS_USBIRQ, 32'hff);
    $display("transfer to endpoint %0d done", ep);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
    {avs_byteenable, line_dp, line_dm, vbus_session_valid, m_pid, m_nak} = {4'hf, 11'h500};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    chk("reset", {avs_waitrequest, tx_token_valid, dplus_pullup_enable}, 3'h4);
    for (int r = 0; r < 8; r++) begin
      bus(rows[r].rd, rows[r].a, rows[r].d);
      if (rows[r].rd) chk("table", q, rows[r].d);
    end
    $display("register table done");
    bus(0, `UHS_OFS_OTGCTL, 32'hc1);
    repeat (2) @(posedge clk);
    chk("pullups on", {dplus_pullup_enable, dminus_pullup_enable, vbus_discharge_enable}, 7);
    bus(0, `UHS_OFS_OTGCTL, 32'h00);
    repeat (2) @(posedge clk);
    chk("pullups off", {dplus_pullup_enable, dminus_pullup_enable, vbus_discharge_enable}, 0);
    bus(0, `UHS_OFS_CFG2, 32'h10);
    repeat (2) @(posedge clk);
    chk("vbus pulse", vbus_pulse_enable, 1);
    bus(0, `UHS_OFS_EPCTL, 32'h9d);
    repeat (2) @(posedge clk);
    chk("low speed", {tx_low_speed, vbus_pulse_enable}, 2);
    bus(0, `UHS_OFS_EPCTL, 32'h1d);
    $display("otg controls done");
    xfer(4'h3, 0, 2, `UHS_PID_ACK, `UHS_PID_ACK, 3);
    bus(0, `UHS_OFS_EPCTL, 32'h5d);
    xfer(4'h5, 1, 0, `UHS_PID_STALL, `UHS_PID_STALL, 1);
    xfer(4'h7, 0, 1, `UHS_PID_ACK, `UHS_PID_NAK, 1);
    xfer(4'h2, 1, 0, 4'h0, `UHS_PID_ERR, 1);
    t0 = n_tok;
    bus(0, `UHS_OFS_BD_EVEN, 32'h0040);
    bus(0, `UHS_OFS_TOKEN, 32'h11);
    repeat (40) @(posedge clk);
    chk("not owned", n_tok - t0, 0);
    $display("owner test done");
    @(posedge clk);
    line_dp <= 1'b0;
    repeat (45) @(posedge clk);
    line_dp <= 1'b1;
    bus(1, `UHS_OFS_USBIRQ, 0);
    chk("short se0", q, 0);
    line_dp <= 1'b0;
    repeat (60) @(posedge clk);
    line_dp <= 1'b1;
    repeat (5) @(posedge clk);
    bus(1, `UHS_OFS_USBIRQ, 0);
    chk("detach attach", q, 32'h41);
    bus(0, `UHS_OFS_USBIRQ, 32'h00);
    bus(1, `UHS_OFS_USBIRQ, 0);
    chk("write zero", q, 32'h41);
    bus(0, `UHS_OFS_OTGIRQ, 32'hff);
    vbus_session_valid <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1, `UHS_OFS_OTGIRQ, 0);
    chk("session end", q, 32'h04);
    vbus_session_valid <= 1'b1;
    repeat (5) @(posedge clk);
    bus(1, `UHS_OFS_OTGIRQ, 0);
    chk("session valid", q, 32'h0c);
    bus(0, `UHS_OFS_OTGCTL, 32'h80);
    repeat (2) @(posedge clk);
    chk("reconnect", dplus_pullup_enable, 1);
    bus(0, `UHS_OFS_OTGIRQ, 32'h0c);
    bus(1, `UHS_OFS_OTGIRQ, 0);
    chk("write one", q, 0);
    $display("line and vbus events done");
    print_verdict;
  end
endmodule
bind uhs_host_ctrl uhs_host_ctrl_checker u_uhs_host_ctrl_checker (.*);
